// file: shared/dcf_defs.vh
// Constants shared by the dual-flag buffer and its storage array.
// Assumes inclusion by bare name from files under src/.
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

// ****************************************************************
// Geometry
// ****************************************************************
`define DCF_DW 18
`define DCF_AW 9
`define DCF_CW 10
`define DCF_DEPTH 10'h200
`define DCF_HALF 10'h100
`define DCF_LAST_LOC 9'h1ff
`define DCF_OFS_DEFAULT 9'h03f

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define DCF_ADDR_CTRL 12'h000
`define DCF_ADDR_EMPTY_OFS 12'h004
`define DCF_ADDR_FULL_OFS 12'h008
`define DCF_ADDR_STATUS 12'h00c
`define DCF_CTRL_RESET 2'h1
`define DCF_CTRL_SYNC_BIT 0
`define DCF_CTRL_CASCADE_BIT 1
`define DCF_CTRL_RETX_BIT 2

// ****************************************************************
// Timing
// ****************************************************************
`define DCF_CLK_NS 5
`define DCF_RTR_NS 15
// Recovery cycles: the recovery time in whole clock periods, rounded up.
`define DCF_RTR_CYC 2'h3
`define DCF_HTRANS_NONSEQ 2'h2

`endif

// file: src/dcf_store.v
// Storage array of the buffer: one write port, one combinational read port.
// Assumes the caller guards writes against overflow.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"

module dcf_store (
    // Clock
    input wire hclk,
    // Write port
    input wire wr_fire,
    input wire [`DCF_AW-1:0] wr_addr,
    input wire [`DCF_DW-1:0] wr_word,
    // Read port
    input wire [`DCF_AW-1:0] rd_addr,
    output wire [`DCF_DW-1:0] rd_word
);

    reg [`DCF_DW-1:0] mem [0:`DCF_DEPTH-1];

    always @(posedge hclk) begin
        if (wr_fire) begin
            mem[wr_addr] <= wr_word;
        end
    end

    assign rd_word = mem[rd_addr];

endmodule
`default_nettype wire

// file: src/dcf_fifo.v
// First-in first-out buffer, 512 words of 18 bits, with programmable
// almost-empty and almost-full flags, retransmit and cascade outputs.
// Assumes writer, reader and bus master all run on hclk.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"

// Functional notes
// - Full flag releases in the same cycle as the read that frees space.
// - Empty flag releases in the same cycle as the write that fills it.
// - Reset works while write and read activity keep toggling.
// - After reset, data outputs low; rd_data_oe stays low until oe_n is sampled low.
// - First written word appears in the read cycle after empty releases.
// - Extra first-read latency only applies at the empty boundary.
// - Almost-empty updates on the read-side cycle of the changing count.
// - Almost-full updates on the write-side cycle of the changing count.
// - Almost-empty asserts when stored count falls to the empty offset.
// - Almost-full asserts when count reaches depth minus full offset plus one.
// - After retransmit every flag is correct once recovery elapses, except when a write fires in the request cycle and leaves the count one low.
// - Offset registers read back through the same path they are written.
// - Both offsets reset to 63 for the 512-word depth.
// - Synchronous flag mode sets almost flags from the settled count, one edge later; otherwise from the next count.
module dcf_fifo (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Writer side
    input wire wr_en_n,
    input wire [`DCF_DW-1:0] wr_data,
    output reg full_n,
    output reg almost_full_n,
    output reg cascade_wr_out_n,
    // Reader side
    input wire rd_en_n,
    input wire oe_n,
    output reg [`DCF_DW-1:0] rd_data,
    output reg rd_data_oe,
    output reg empty_n,
    output reg almost_empty_n,
    output reg cascade_rd_out_n
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg [1:0] ctrl_reg;
    reg [`DCF_AW-1:0] empty_ofs_reg;
    reg [`DCF_AW-1:0] full_ofs_reg;
    reg [`DCF_AW-1:0] wr_ptr_reg;
    reg [`DCF_AW-1:0] rd_ptr_reg;
    reg [`DCF_CW-1:0] count_reg;
    reg [`DCF_CW-1:0] count_next;
    reg [1:0] rtr_cnt_reg;
    reg dph_valid_reg;
    reg dph_write_reg;
    reg [11:0] dph_addr_reg;
    reg [31:0] rdata_next;
    wire [`DCF_DW-1:0] store_word;
    wire addr_phase;
    wire wr_fire;
    wire rd_fire;
    wire rtr_busy;
    wire retx_req;
    wire sync_mode;
    wire [`DCF_CW:0] af_level;
    wire ae_now;
    wire af_now;
    wire ae_next;
    wire af_next;

    assign addr_phase = hsel & hready & (htrans == `DCF_HTRANS_NONSEQ);
    assign sync_mode = ~ctrl_reg[`DCF_CTRL_SYNC_BIT];
    assign retx_req = dph_valid_reg & dph_write_reg & (dph_addr_reg == `DCF_ADDR_CTRL)
        & hwdata[`DCF_CTRL_RETX_BIT];
    assign rtr_busy = (rtr_cnt_reg != 2'h0);

    // ****************************************************************
    // Transfer qualification
    // ****************************************************************
    assign wr_fire = ~wr_en_n & (count_reg != `DCF_DEPTH) & ~rtr_busy;
    assign rd_fire = ~rd_en_n & (count_reg != 10'h000) & ~rtr_busy;

    // ****************************************************************
    // Storage
    // ****************************************************************
    dcf_store u_store (
        .hclk(hclk),
        .wr_fire(wr_fire),
        .wr_addr(wr_ptr_reg),
        .wr_word(wr_data),
        .rd_addr(rd_ptr_reg),
        .rd_word(store_word)
    );

    // ****************************************************************
    // Fill level
    // ****************************************************************
    always @* begin
        count_next = count_reg;
        if (retx_req) begin
            count_next = {1'b0, wr_ptr_reg};
        end else if (wr_fire & ~rd_fire) begin
            count_next = count_reg + 10'h001;
        end else if (rd_fire & ~wr_fire) begin
            count_next = count_reg - 10'h001;
        end
    end

    // The almost-full threshold is compared one bit wider so depth plus one cannot wrap.
    assign af_level = {1'b0, `DCF_DEPTH} + 11'h001 - {2'b00, full_ofs_reg};
    assign ae_now = (count_reg <= {1'b0, empty_ofs_reg});
    assign af_now = ({1'b0, count_reg} >= af_level);
    assign ae_next = (count_next <= {1'b0, empty_ofs_reg});
    assign af_next = ({1'b0, count_next} >= af_level);

    // ****************************************************************
    // Pointers
    // ****************************************************************
    // Reset clears both pointers regardless of transfer requests in flight.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= {`DCF_AW{1'b0}};
            rd_ptr_reg <= {`DCF_AW{1'b0}};
        end else begin
            if (wr_fire) begin
                wr_ptr_reg <= wr_ptr_reg + 9'h001;
            end
            if (retx_req) begin
                rd_ptr_reg <= {`DCF_AW{1'b0}};
            end else if (rd_fire) begin
                rd_ptr_reg <= rd_ptr_reg + 9'h001;
            end
        end
    end

    // ****************************************************************
    // Fill count and retransmit recovery
    // ****************************************************************
    // Recovery blocks both ports so the count cannot move under the flags.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= {`DCF_CW{1'b0}};
            rtr_cnt_reg <= 2'h0;
        end else begin
            count_reg <= count_next;
            if (retx_req) begin
                rtr_cnt_reg <= `DCF_RTR_CYC;
            end else if (rtr_busy) begin
                rtr_cnt_reg <= rtr_cnt_reg - 2'h1;
            end
        end
    end

    // ****************************************************************
    // Empty and full flags
    // ****************************************************************
    // Single clock: the skew window is always met, so both flags
    // release on the very edge that moves the count.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_n <= 1'b0;
            full_n <= 1'b1;
        end else begin
            empty_n <= (count_next != 10'h000);
            full_n <= (count_next != `DCF_DEPTH);
        end
    end

    // ****************************************************************
    // Almost-empty and almost-full flags
    // ****************************************************************
    // Synchronous mode looks at the settled count, so it trails by one edge.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            almost_empty_n <= 1'b0;
            almost_full_n <= 1'b1;
        end else begin
            if (sync_mode) begin
                almost_empty_n <= ~ae_now;
                almost_full_n <= ~af_now;
            end else begin
                almost_empty_n <= ~ae_next;
                almost_full_n <= ~af_next;
            end
        end
    end

    // ****************************************************************
    // Cascade outputs
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cascade_wr_out_n <= 1'b1;
            cascade_rd_out_n <= 1'b1;
        end else begin
            if (ctrl_reg[`DCF_CTRL_CASCADE_BIT]) begin
                cascade_wr_out_n <= ~(wr_fire & (wr_ptr_reg == `DCF_LAST_LOC));
                cascade_rd_out_n <= ~(rd_fire & (rd_ptr_reg == `DCF_LAST_LOC));
            end else begin
                // Stand-alone use: the write expansion pin shows half full.
                cascade_wr_out_n <= ~(count_next > `DCF_HALF);
                cascade_rd_out_n <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Read data path
    // ****************************************************************
    // Data is registered from the array, so the first word lands on the
    // edge of the read that follows the empty flag release.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= {`DCF_DW{1'b0}};
            rd_data_oe <= 1'b0;
        end else begin
            rd_data_oe <= ~oe_n;
            if (rd_fire) begin
                rd_data <= store_word;
            end
        end
    end
    // The empty-boundary latency arises only from count_reg gating reads.

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    always @* begin
        rdata_next = 32'h0000_0000;
        if (haddr[11:0] == `DCF_ADDR_CTRL) begin
            rdata_next[1:0] = ctrl_reg;
        end else if (haddr[11:0] == `DCF_ADDR_EMPTY_OFS) begin
            rdata_next[`DCF_AW-1:0] = empty_ofs_reg;
        end else if (haddr[11:0] == `DCF_ADDR_FULL_OFS) begin
            rdata_next[`DCF_AW-1:0] = full_ofs_reg;
        end else if (haddr[11:0] == `DCF_ADDR_STATUS) begin
            rdata_next[`DCF_CW-1:0] = count_reg;
            rdata_next[16] = empty_n;
            rdata_next[17] = full_n;
            rdata_next[18] = almost_empty_n;
            rdata_next[19] = almost_full_n;
            rdata_next[20] = rtr_busy;
        end
    end

    // ****************************************************************
    // Bus response
    // ****************************************************************
    // Every access completes without wait states and always succeeds.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************************************
    // Data phase tracking and read data
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            dph_valid_reg <= 1'b0;
            dph_write_reg <= 1'b0;
            dph_addr_reg <= 12'h000;
        end else begin
            dph_valid_reg <= addr_phase;
            dph_write_reg <= hwrite;
            dph_addr_reg <= haddr[11:0];
            // Read data is captured in the address phase so it stands for the whole data phase.
            if (addr_phase & ~hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Write data arrives one cycle after the address, so the decode uses the held address.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `DCF_CTRL_RESET;
            empty_ofs_reg <= `DCF_OFS_DEFAULT;
            full_ofs_reg <= `DCF_OFS_DEFAULT;
        end else begin
            if (dph_valid_reg & dph_write_reg) begin
                if (dph_addr_reg == `DCF_ADDR_CTRL) begin
                    ctrl_reg <= hwdata[1:0];
                end else if (dph_addr_reg == `DCF_ADDR_EMPTY_OFS) begin
                    empty_ofs_reg <= hwdata[`DCF_AW-1:0];
                end else if (dph_addr_reg == `DCF_ADDR_FULL_OFS) begin
                    full_ofs_reg <= hwdata[`DCF_AW-1:0];
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: testbench/dcf_props.sv
// Port checker for the buffer.
// Assumes it is bound onto dcf_fifo, all traffic on hclk.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"
module dcf_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Writer side
    input wire logic wr_en_n,
    input wire logic [`DCF_DW-1:0] wr_data,
    input wire logic full_n,
    // Reader side
    input wire logic rd_en_n,
    input wire logic oe_n,
    input wire logic [`DCF_DW-1:0] rd_data,
    input wire logic rd_data_oe,
    input wire logic empty_n,
    input wire logic almost_empty_n
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_full_release: assert property (!full_n && !rd_en_n && wr_en_n |=> full_n)
        else $error("full flag held after a read");
    chk_empty_release: assert property (!empty_n && !wr_en_n && rd_en_n |=> empty_n)
        else $error("empty flag held after a write");
    chk_first_word: assert property ((!empty_n && !wr_en_n) ##1 !rd_en_n |=> rd_data == $past(wr_data, 2))
        else $error("first word late or wrong");
    chk_oe_on: assert property ($fell(oe_n) |=> rd_data_oe)
        else $error("output drive not enabled");
    chk_reset_state: assert property ($rose(hresetn) |-> !empty_n && full_n && rd_data == 18'h0_0000)
        else $error("wrong state after reset");
    chk_full_refuse: assert property (!full_n && !wr_en_n && rd_en_n |=> !full_n)
        else $error("write taken while full");
    chk_empty_hold: assert property (!empty_n && !rd_en_n && wr_en_n |=> !empty_n && $stable(rd_data))
        else $error("read taken while empty");
    chk_ae_empty: assert property (!empty_n [*2] |-> !almost_empty_n)
        else $error("almost empty flag high while empty");
endmodule
bind dcf_fifo dcf_props i_dcf_props (.hclk(hclk), .hresetn(hresetn), .wr_en_n(wr_en_n), .wr_data(wr_data),
    .full_n(full_n), .rd_en_n(rd_en_n), .oe_n(oe_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .empty_n(empty_n), .almost_empty_n(almost_empty_n));
`default_nettype wire

// file: testbench/dcf_partner.sv
// Writer and reader model for the buffer's data ports.
// Assumes the bench calls xfer once for each clock it wants driven.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"
module dcf_partner (
    // Clock
    input wire logic hclk,
    // Writer and reader
    output var logic wr_en_n,
    output var logic [`DCF_DW-1:0] wr_data,
    output var logic rd_en_n,
    output var logic oe_n
);
    // ********
    // Drivers
    // ********
    initial begin
        wr_en_n = 1'b1;
        wr_data = 18'h0_0000;
        rd_en_n = 1'b1;
        oe_n = 1'b1;
    end
    // Idle data lines invert on every idle clock, alternating between the last word and its inverse.
    task automatic xfer(input logic w, input logic r, input logic [`DCF_DW-1:0] d);
        @(posedge hclk);
        wr_en_n <= !w;
        rd_en_n <= !r;
        wr_data <= w ? d : ~wr_data;
    endtask
    task automatic set_oe(input logic e);
        oe_n <= !e;
    endtask
endmodule
`default_nettype wire

// file: testbench/dcf_bench.sv
// Self-checking bench for the buffer.
// Assumes dcf_fifo, dcf_partner and dcf_props are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "dcf_defs.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module dual_clock_fifo_flag_timing_bench;
    localparam logic [`DCF_DW-1:0] NODATA = 18'h0_0000;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, wr_en_n, rd_en_n, oe_n, full_n, almost_full_n, empty_n, almost_empty_n;
    logic cwo_n, cro_n, rd_data_oe;
    logic [`DCF_DW-1:0] wr_data, rd_data;
    int fails = 0, comparisons = 0, eo = 63, fo = 63;
    always #2.5 hclk = ~hclk;
    dcf_partner i_dcf_partner (.hclk(hclk), .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n), .oe_n(oe_n));
    dcf_fifo i_dcf_fifo (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .wr_en_n(wr_en_n), .wr_data(wr_data), .full_n(full_n),
        .almost_full_n(almost_full_n), .cascade_wr_out_n(cwo_n), .rd_en_n(rd_en_n), .oe_n(oe_n),
        .rd_data(rd_data), .rd_data_oe(rd_data_oe), .empty_n(empty_n), .almost_empty_n(almost_empty_n),
        .cascade_rd_out_n(cro_n));
    // ********
    // Tasks
    // ********
    task automatic finish_test();
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= `DCF_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        `CHK("register", e, q)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic flags(input int c);
        `CHK("almost_empty_n", c > eo, almost_empty_n)
        `CHK("almost_full_n", c < 513 - fo, almost_full_n)
        `CHK("full_n", c < 512, full_n)
        `CHK("empty_n", c > 0, empty_n)
        `CHK("half_full_n", c <= 256, cwo_n)
        `CHK("cascade_rd_out_n", 1'b1, cro_n)
    endtask
    initial begin
        #100000;
        fails++;
        finish_test();
    end
    initial begin
        logic [31:0] q;
        int k;
        for (k = 0; k < 3; k++)
            i_dcf_partner.xfer(k[0], !k[0], 18'h3_ffff);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        hresetn <= 1'b1;
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        flags(0);
        `CHK("oe", 1'b0, rd_data_oe)
        rchk(`DCF_ADDR_CTRL, 32'h0000_0001);
        rchk(`DCF_ADDR_EMPTY_OFS, 32'h0000_003f);
        rchk(`DCF_ADDR_FULL_OFS, 32'h0000_003f);
        rchk(`DCF_ADDR_STATUS, 32'h000a_0000);
        i_dcf_partner.set_oe(1'b1);
        bus(1'b1, `DCF_ADDR_EMPTY_OFS, 32'h0000_0005, q);
        bus(1'b1, `DCF_ADDR_FULL_OFS, 32'h0000_0007, q);
        bus(1'b1, 32'h0000_0010, 32'h0000_1234, q);
        eo = 5;
        fo = 7;
        rchk(`DCF_ADDR_FULL_OFS, 32'h0000_0007);
        rchk(32'h0000_0010, 32'h0000_0000);
        `CHK("oe", 1'b1, rd_data_oe)
        `CHK("rd_data", NODATA, rd_data)
        i_dcf_partner.xfer(1'b1, 1'b0, 18'h2_a5a5);
        i_dcf_partner.xfer(1'b0, 1'b1, NODATA);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        `CHK("first", 18'h2_a5a5, rd_data)
        for (k = 0; k <= 512; k++) begin
            i_dcf_partner.xfer(k < 512, 1'b0, 18'(k));
            #1;
            flags(k);
        end
        i_dcf_partner.xfer(1'b1, 1'b0, 18'h3_0000);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        flags(512);
        for (k = 0; k <= 512; k++) begin
            i_dcf_partner.xfer(1'b0, k < 512, NODATA);
            #1;
            flags(512 - k);
            if (k > 0)
                `CHK("rd_data", 18'(k - 1), rd_data)
        end
        i_dcf_partner.xfer(1'b0, 1'b1, NODATA);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        `CHK("rd_hold", 18'h0_01ff, rd_data)
        bus(1'b1, `DCF_ADDR_CTRL, 32'h0000_0000, q);
        for (k = 0; k < 6; k++)
            i_dcf_partner.xfer(1'b1, 1'b0, 18'(k + 256));
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        `CHK("sync_ae", 1'b0, almost_empty_n)
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        `CHK("sync_ae", 1'b1, almost_empty_n)
        i_dcf_partner.xfer(1'b0, 1'b1, NODATA);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        bus(1'b1, `DCF_ADDR_CTRL, 32'h0000_0004, q);
        k = 0;
        do begin
            bus(1'b0, `DCF_ADDR_STATUS, 32'h0000_0000, q);
            k++;
        end while (q[20] !== 1'b0 && k < 8);
        `CHK("recovery", 1'b0, q[20])
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        flags(7);
        i_dcf_partner.xfer(1'b0, 1'b1, NODATA);
        i_dcf_partner.xfer(1'b0, 1'b0, NODATA);
        #1;
        `CHK("retransmit", 18'h0_01ff, rd_data)
        finish_test();
    end
endmodule
`default_nettype wire
